// *** hdl/scf_core.sv ***
// Serial command decoder with open-load filter and fault response word
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Decode retry, amplitude, frequency for second driver
// - Thermal query answers per-output thermal flags
// - Over-voltage bit one when present
// - Trim bit zero untrimmed, one trimmed
// - Two fault messages, top bit over-voltage/thermal
// - Open load sensed only while output off
// - Pull-downs enabled at power-up
// - Open-load bit zero when pull-down disabled
// - Pull-down off only by sleep or command
// - Open-load filter 1 cycle to 450 us, 100 us by default
// - Chip-select rise starts filter timer
// - Open-load fault latched until read
// - Outputs resume when supply faults clear; open load never turns them off
// - Under-voltage shuts outputs, resets controls
// - Low-voltage band keeps commanded outputs
// - Over-voltage holds outputs off until normal
module scf_core #(
   parameter int unsigned FILT_CYC = scf_pkg::OL_FILT_CYC
) (
   input  wire logic                        core_clk,
   input  wire logic                        reset_n,
   input  wire logic                        sclk,
   input  wire logic                        cs_n,
   input  wire logic                        mosi,
   output logic                             miso,
   output logic                             miso_oe,
   input  wire logic [scf_pkg::NUM_OUT-1:0] out_cmd_on,
   input  wire logic [scf_pkg::NUM_OUT-1:0] pulldown_dis,
   input  wire logic                        sleep_mode,
   input  wire logic [scf_pkg::NUM_OUT-1:0] open_cmp,
   input  wire logic [scf_pkg::NUM_OUT-1:0] out_fault,
   input  wire logic [scf_pkg::NUM_OUT-1:0] thermal_limit_oss,
   input  wire logic                        thermal_limit_first_current_driver,
   input  wire logic                        cal_freq_high,
   input  wire logic                        cal_freq_low,
   input  wire logic                        over_voltage_flag,
   input  wire logic                        under_voltage,
   input  wire logic                        low_voltage,
   input  wire logic                        trimmed,
   input  wire logic                        msg_select,
   output logic [scf_pkg::NUM_OUT-1:0]      out_enable,
   output logic [scf_pkg::NUM_OUT-1:0]      pulldown_en,
   output logic                             second_current_driver_retry,
   output logic [2:0]                       second_current_driver_amp,
   output logic [3:0]                       second_current_driver_freq,
   output logic [10:0]                      second_current_driver_ctl,
   output logic                             status_unreliable,
   output logic [scf_pkg::WORD_W-1:0]       serial_fault_response
);
   // Filter reload must fit the counter and the longest allowed delay
   localparam int unsigned FILT_MAX = scf_pkg::OL_FILT_MAX_US * scf_pkg::CLK_MHZ;
   localparam int unsigned FILT_W   = $clog2(FILT_MAX + 1);
   if (FILT_CYC < 1 || FILT_CYC > FILT_MAX) begin : g_bad_filt
      $error("FILT_CYC out of range");
   end


   logic [1:0] rst_sync_r;
   logic       rst_n;
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) rst_sync_r <= 2'b00;
      else rst_sync_r <= {rst_sync_r[0], 1'b1};
   end
   assign rst_n = rst_sync_r[1];

   // Pin synchronisers, three stages, change taken when stages two and three agree
   logic [2:0] sclk_s_r, cs_s_r, mosi_s_r;
   logic       sclk_q_r, cs_q_r, mosi_q_r;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_s_r <= 3'b000;
         cs_s_r   <= 3'b111;
         mosi_s_r <= 3'b000;
         sclk_q_r <= 1'b0;
         cs_q_r   <= 1'b1;
         mosi_q_r <= 1'b0;
      end else begin
         sclk_s_r <= {sclk_s_r[1:0], sclk};
         cs_s_r   <= {cs_s_r[1:0], cs_n};
         mosi_s_r <= {mosi_s_r[1:0], mosi};
         if (sclk_s_r[1] == sclk_s_r[2]) sclk_q_r <= sclk_s_r[2];
         if (cs_s_r[1] == cs_s_r[2]) cs_q_r <= cs_s_r[2];
         if (mosi_s_r[1] == mosi_s_r[2]) mosi_q_r <= mosi_s_r[2];
      end
   end

   logic sclk_d_r, cs_d_r;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_d_r <= 1'b0;
         cs_d_r   <= 1'b1;
      end else begin
         sclk_d_r <= sclk_q_r;
         cs_d_r   <= cs_q_r;
      end
   end
   logic sclk_rise, sclk_fall, cs_fall, cs_rise;
   assign sclk_rise = sclk_q_r & ~sclk_d_r;
   assign sclk_fall = ~sclk_q_r & sclk_d_r;
   assign cs_fall   = ~cs_q_r & cs_d_r;
   assign cs_rise   = cs_q_r & ~cs_d_r;

   // Shift registers; word completes on chip-select rise after 16 bits
   logic [15:0] rx_r, tx_r;
   logic [4:0]  bit_cnt_r;
   logic        word_ok;
   assign word_ok = cs_rise && (bit_cnt_r == 5'(scf_pkg::WORD_W));
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_r      <= 16'h0000;
         bit_cnt_r <= 5'h00;
      end else if (cs_fall) begin
         bit_cnt_r <= 5'h00;
      end else if (!cs_q_r && sclk_rise) begin
         rx_r <= {rx_r[14:0], mosi_q_r};
         if (bit_cnt_r != 5'h1F) bit_cnt_r <= bit_cnt_r + 5'h01;
      end
   end

   function automatic logic [4:0] addr_of(input logic [15:0] w);
      addr_of = w[scf_pkg::ADDR_HI:scf_pkg::ADDR_LO];
   endfunction

   logic uv_or_ov;
   assign uv_or_ov = under_voltage | over_voltage_flag;

   // Second driver settings
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         second_current_driver_retry <= 1'b0;
         second_current_driver_amp   <= 3'h0;
         second_current_driver_freq  <= 4'h0;
         second_current_driver_ctl   <= 11'h000;
      end else if (under_voltage) begin
         second_current_driver_retry <= 1'b0;
         second_current_driver_amp   <= 3'h0;
         second_current_driver_freq  <= 4'h0;
         second_current_driver_ctl   <= 11'h000;
      end else if (word_ok) begin
         if (addr_of(rx_r) == scf_pkg::ADDR_SECOND_CURRENT_DRIVER_FA) begin
            second_current_driver_retry <= rx_r[scf_pkg::RETRY_BIT];
            second_current_driver_amp   <= rx_r[scf_pkg::AMP_HI:scf_pkg::AMP_LO];
            second_current_driver_freq  <= rx_r[scf_pkg::FRQ_HI:scf_pkg::FRQ_LO];
         end else if (addr_of(rx_r) == scf_pkg::ADDR_SECOND_CURRENT_DRIVER_CTL) begin
            second_current_driver_ctl <= rx_r[scf_pkg::CTL_HI:0];
         end
      end
   end

   // Response selection; query answer is the next word out
   scf_pkg::scf_rsp_e rsp_sel_r;
   logic              reset_seen_r;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rsp_sel_r    <= scf_pkg::SCF_MSG1;
         reset_seen_r <= 1'b1;
      end else if (under_voltage) begin
         reset_seen_r <= 1'b1;
      end else if (word_ok) begin
         // Reset flag stays up until a second message has carried it out
         if (rsp_sel_r == scf_pkg::SCF_MSG2) reset_seen_r <= 1'b0;
         if (addr_of(rx_r) == scf_pkg::ADDR_TL_QUERY) rsp_sel_r <= scf_pkg::SCF_THERMAL_LIMIT;
         else if (msg_select) rsp_sel_r <= scf_pkg::SCF_MSG2;
         else rsp_sel_r <= scf_pkg::SCF_MSG1;
      end
   end

   // Pull-downs and open-load filter
   logic [FILT_W-1:0] filt_cnt_r;
   logic              filt_done;
   assign filt_done = (filt_cnt_r == '0);
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) filt_cnt_r <= FILT_W'(FILT_CYC);
      else if (cs_rise) filt_cnt_r <= FILT_W'(FILT_CYC);
      else if (!filt_done) filt_cnt_r <= filt_cnt_r - FILT_W'(1);
   end

   logic [7:0] ol_latch_r;
   logic       clr_ol;
   assign clr_ol = word_ok && (rsp_sel_r == scf_pkg::SCF_MSG2);
   genvar g;
   generate
      for (g = 0; g < scf_pkg::NUM_OUT; g++) begin : g_out
         // pull-down on from reset; only sleep or command disables
         assign pulldown_en[g] = ~sleep_mode & ~pulldown_dis[g];
         // supply faults force off; low band keeps command; resume
         assign out_enable[g] = out_cmd_on[g] & ~uv_or_ov;
         logic ol_hit;
         assign ol_hit = ~out_cmd_on[g] & open_cmp[g] & filt_done & pulldown_en[g];
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) ol_latch_r[g] <= 1'b0;
            else if (!pulldown_en[g]) ol_latch_r[g] <= 1'b0;
            else if (ol_hit) ol_latch_r[g] <= 1'b1;
            else if (clr_ol) ol_latch_r[g] <= 1'b0;
         end
      end
   endgenerate
   assign status_unreliable = low_voltage;

   logic [15:0] rsp_word;
   logic        top_fault;
   assign top_fault = over_voltage_flag | thermal_limit_first_current_driver | (|thermal_limit_oss);
   always_comb begin
      rsp_word = scf_pkg::RSP_RESET_VAL;
      case (rsp_sel_r)
         scf_pkg::SCF_THERMAL_LIMIT: begin
            // thermal flags per output; over-voltage one when present
            rsp_word[scf_pkg::TL_OSS_LO +: scf_pkg::NUM_OUT] = thermal_limit_oss;
            rsp_word[scf_pkg::TL_FIRST_CURRENT_DRIVER_BIT]   = thermal_limit_first_current_driver;
            rsp_word[scf_pkg::TL_OV_BIT]     = over_voltage_flag;
            rsp_word[scf_pkg::TL_CAL_LO_BIT] = cal_freq_low;
            rsp_word[scf_pkg::TL_CAL_HI_BIT] = cal_freq_high;
         end
         scf_pkg::SCF_MSG2: begin
            // second message; trim state; no pull-down reads zero
            rsp_word[scf_pkg::RSP_FAULT_BIT] = top_fault;
            rsp_word[scf_pkg::RSP_RESET_BIT] = reset_seen_r;
            rsp_word[scf_pkg::RSP_TRIM_BIT]  = trimmed;
            rsp_word[7:0] = ol_latch_r & pulldown_en;
         end
         scf_pkg::SCF_MSG1: begin
            rsp_word[scf_pkg::RSP_FAULT_BIT] = top_fault;
            rsp_word[7:0] = out_fault;
         end
         default: rsp_word = scf_pkg::RSP_RESET_VAL;
      endcase
   end

   // Load on chip-select fall, shift on clock fall, MSB first
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_r                  <= 16'h0000;
         serial_fault_response <= 16'h0000;
      end else if (cs_fall) begin
         tx_r                  <= rsp_word;
         serial_fault_response <= rsp_word;
      end else if (!cs_q_r && sclk_fall) begin
         tx_r <= {tx_r[14:0], 1'b0};
      end
   end
   assign miso    = tx_r[15];
   assign miso_oe = ~cs_q_r;

   chk_ol_filter: assert property (@(posedge core_clk) disable iff (!rst_n)
      cs_rise |=> !filt_done) else $error("filter not restarted");
   chk_ol_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
      !pulldown_en[0] |=> !ol_latch_r[0]) else $error("open-load bit not zero");
   chk_out_off: assert property (@(posedge core_clk) disable iff (!rst_n)
      over_voltage_flag |-> out_enable == 8'h00) else $error("output on at over-voltage");
   chk_uv_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
      under_voltage |=> second_current_driver_amp == 3'h0 && second_current_driver_freq == 4'h0) else $error("control kept");
   chk_ol_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      ol_latch_r[0] && pulldown_en[0] && !clr_ol |=> ol_latch_r[0]) else $error("latch lost");
   chk_pd_on: assert property (@(posedge core_clk) disable iff (!rst_n)
      !sleep_mode && !pulldown_dis[0] |-> pulldown_en[0]) else $error("pull-down off");
   chk_tl_ov: assert property (@(posedge core_clk) disable iff (!rst_n)
      rsp_sel_r == scf_pkg::SCF_THERMAL_LIMIT |-> rsp_word[scf_pkg::TL_OV_BIT] == over_voltage_flag)
      else $error("over-voltage bit wrong");
   chk_inval_nop: assert property (@(posedge core_clk) disable iff (!rst_n)
      word_ok && addr_of(rx_r) == scf_pkg::ADDR_INVAL_A && !under_voltage
      |=> $stable(second_current_driver_amp) && $stable(second_current_driver_ctl)) else $error("invalid word changed state");
   chk_filt_len: assert property (@(posedge core_clk) disable iff (!rst_n)
      cs_rise |=> filt_cnt_r == FILT_W'(FILT_CYC)) else $error("filter reload wrong");
   chk_word_load: assert property (@(posedge core_clk) disable iff (!rst_n)
      cs_fall |=> serial_fault_response == $past(rsp_word)) else $error("response not loaded");
   chk_trim_bit: assert property (@(posedge core_clk) disable iff (!rst_n)
      rsp_sel_r == scf_pkg::SCF_MSG2 |-> rsp_word[scf_pkg::RSP_TRIM_BIT] == trimmed)
      else $error("trim bit wrong");
   chk_fa_decode: assert property (@(posedge core_clk) disable iff (!rst_n)
      word_ok && addr_of(rx_r) == scf_pkg::ADDR_SECOND_CURRENT_DRIVER_FA && !under_voltage
      |=> second_current_driver_freq == rx_r[scf_pkg::FRQ_HI:scf_pkg::FRQ_LO]
         && second_current_driver_amp == rx_r[scf_pkg::AMP_HI:scf_pkg::AMP_LO])
      else $error("frequency or amplitude not decoded");
   chk_ctl_decode: assert property (@(posedge core_clk) disable iff (!rst_n)
      word_ok && addr_of(rx_r) == scf_pkg::ADDR_SECOND_CURRENT_DRIVER_CTL && !under_voltage
      |=> second_current_driver_ctl == rx_r[scf_pkg::CTL_HI:0]) else $error("control word not decoded");
   chk_ol_sense: assert property (@(posedge core_clk) disable iff (!rst_n)
      out_cmd_on[0] && !ol_latch_r[0] |=> !ol_latch_r[0]) else $error("open load set while on");
   chk_pd_cmd: assert property (@(posedge core_clk) disable iff (!rst_n)
      pulldown_dis[0] || sleep_mode |-> !pulldown_en[0]) else $error("pull-down left on");
   chk_low_band: assert property (@(posedge core_clk) disable iff (!rst_n)
      low_voltage && !under_voltage && !over_voltage_flag |-> out_enable == out_cmd_on)
      else $error("low band changed outputs");
   chk_uv_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
      under_voltage |=> reset_seen_r) else $error("reset flag not set");
   chk_ov_top: assert property (@(posedge core_clk) disable iff (!rst_n)
      over_voltage_flag && rsp_sel_r != scf_pkg::SCF_THERMAL_LIMIT |-> rsp_word[scf_pkg::RSP_FAULT_BIT])
      else $error("top fault bit clear");

   cov_query: cover property (@(posedge core_clk)
      word_ok && addr_of(rx_r) == scf_pkg::ADDR_TL_QUERY);
   cov_fa: cover property (@(posedge core_clk) word_ok && addr_of(rx_r) == scf_pkg::ADDR_SECOND_CURRENT_DRIVER_FA);
   cov_ol: cover property (@(posedge core_clk) |ol_latch_r);
   cov_msg2: cover property (@(posedge core_clk) clr_ol && |ol_latch_r);
   cov_uv: cover property (@(posedge core_clk) under_voltage && |second_current_driver_ctl);
endmodule
`default_nettype wire

// *** hdl/scf_pkg.sv ***
// Constants and types for the serial command and fault status block
package scf_pkg;
   localparam int unsigned WORD_W        = 16;
   localparam int unsigned NUM_OUT       = 8;
   localparam int unsigned CLK_MHZ       = 200;
   localparam int unsigned OL_FILT_MIN_US = 100;
   localparam int unsigned OL_FILT_MAX_US = 450;
   // Least filter time in whole cycles, 100 us at 200 MHz
   localparam int unsigned OL_FILT_CYC   = OL_FILT_MIN_US * CLK_MHZ;
   // Command address field, bits 15..11
   localparam int unsigned ADDR_HI       = 15;
   localparam int unsigned ADDR_LO       = 11;
   localparam logic [4:0]  ADDR_SECOND_CURRENT_DRIVER_CTL = 5'h18;
   localparam logic [4:0]  ADDR_SECOND_CURRENT_DRIVER_FA  = 5'h19;
   localparam logic [4:0]  ADDR_TL_QUERY = 5'h1C;
   localparam logic [4:0]  ADDR_INVAL_A  = 5'h1D;
   localparam logic [4:0]  ADDR_INVAL_B  = 5'h1E;
   // Retry, frequency and amplitude fields
   localparam int unsigned RETRY_BIT     = 10;
   localparam int unsigned AMP_HI        = 6;
   localparam int unsigned AMP_LO        = 4;
   localparam int unsigned FRQ_HI        = 3;
   localparam int unsigned FRQ_LO        = 0;
   // Control word of the second current driver, bits 10..0
   localparam int unsigned CTL_HI        = 10;
   // Response fields
   localparam int unsigned RSP_FAULT_BIT = 15;
   localparam int unsigned RSP_RESET_BIT = 14;
   localparam int unsigned RSP_TRIM_BIT  = 13;
   localparam int unsigned TL_CAL_HI_BIT = 12;
   localparam int unsigned TL_CAL_LO_BIT = 11;
   localparam int unsigned TL_OV_BIT     = 10;
   localparam int unsigned TL_FIRST_CURRENT_DRIVER_BIT   = 9;
   localparam int unsigned TL_OSS_LO     = 1;
   localparam logic [15:0] RSP_RESET_VAL = 16'h0000;
   typedef enum logic [1:0] {
      SCF_MSG1  = 2'b00,
      SCF_MSG2  = 2'b01,
      SCF_THERMAL_LIMIT  = 2'b10
   } scf_rsp_e;
endpackage

// *** testbench/scf_host_model.sv ***
// Host serial master model that frames 16-bit words
`timescale 1ns/1ps
`default_nettype none
module scf_host_model (
   input  wire logic core_clk,
   input  wire logic miso,
   input  wire logic miso_oe,
   output logic      sclk,
   output logic      cs_n,
   output logic      mosi
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end
   // MSB first, half period five core cycles, clock idle low
   task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
      rx = 16'h0000;
      @(posedge core_clk) cs_n <= 1'b0;
      repeat (8) @(posedge core_clk);
      for (int i = 15; i >= 0; i--) begin
         mosi <= tx[i];
         repeat (5) @(posedge core_clk);
         sclk <= 1'b1;
         // Sample two cycles into the high phase, clear of the shift edge
         repeat (2) @(posedge core_clk);
         rx[i] = miso_oe ? miso : 1'bx;
         repeat (3) @(posedge core_clk);
         sclk <= 1'b0;
      end
      repeat (5) @(posedge core_clk);
      cs_n <= 1'b1;
      // Released data line shows the inverse of its last bit
      mosi <= ~tx[0];
      repeat (8) @(posedge core_clk);
   endtask
endmodule
`default_nettype wire

// *** testbench/spi_command_fault_status_tb.sv ***
// Self-checking bench for the serial command and fault status block
`timescale 1ns/1ps
`default_nettype none
module spi_command_fault_status_tb;
   localparam logic [15:0] TRIM = 16'h2000;
   localparam logic [4:0]  NOP  = scf_pkg::ADDR_INVAL_A;
   logic             core_clk = 1'b0;
   logic             reset_n;
   logic [7:0]       out_cmd_on, pulldown_dis, open_cmp, out_fault, thermal_limit_oss;
   logic             sleep_mode, thermal_limit_first_current_driver, cal_freq_high, cal_freq_low;
   logic             over_voltage_flag, under_voltage, low_voltage, trimmed, msg_select;
   wire logic        sclk, cs_n, mosi, miso, miso_oe, second_current_driver_retry, status_unreliable;
   wire logic [7:0]  out_enable, pulldown_en;
   wire logic [2:0]  second_current_driver_amp;
   wire logic [3:0]  second_current_driver_freq;
   wire logic [10:0] second_current_driver_ctl;
   wire logic [15:0] sfr;
   logic [15:0]      rx;
   int               n_errors = 0;
   int               n_checks = 0;
   int               cycles = 0;
   always #2.5 core_clk = ~core_clk;
   scf_core #(.FILT_CYC(50)) uut (.core_clk(core_clk), .reset_n(reset_n), .sclk(sclk),
      .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .out_cmd_on(out_cmd_on),
      .pulldown_dis(pulldown_dis), .sleep_mode(sleep_mode), .open_cmp(open_cmp),
      .out_fault(out_fault), .thermal_limit_oss(thermal_limit_oss),
      .thermal_limit_first_current_driver(thermal_limit_first_current_driver), .cal_freq_high(cal_freq_high),
      .cal_freq_low(cal_freq_low), .over_voltage_flag(over_voltage_flag),
      .under_voltage(under_voltage), .low_voltage(low_voltage), .trimmed(trimmed),
      .msg_select(msg_select), .out_enable(out_enable), .pulldown_en(pulldown_en),
      .second_current_driver_retry(second_current_driver_retry), .second_current_driver_amp(second_current_driver_amp), .second_current_driver_freq(second_current_driver_freq),
      .second_current_driver_ctl(second_current_driver_ctl), .status_unreliable(status_unreliable),
      .serial_fault_response(sfr));
   scf_host_model host (.core_clk(core_clk), .miso(miso), .miso_oe(miso_oe), .sclk(sclk),
      .cs_n(cs_n), .mosi(mosi));
   task automatic stop_test;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic xf(input logic [4:0] a, input logic [10:0] d);
      host.xfer({a, d}, rx);
   endtask
   // Thermal query, then read back its answer; f is cal high, cal low, over-voltage, driver one
   task automatic tl(input logic [7:0] octal_switch_output, input logic [3:0] f);
      thermal_limit_oss <= octal_switch_output;
      {cal_freq_high, cal_freq_low, over_voltage_flag, thermal_limit_first_current_driver} <= f;
      xf(scf_pkg::ADDR_TL_QUERY, 11'h000);
      xf(NOP, 11'h000);
      chk("thermal_limit rsp", rx, {3'b000, f, octal_switch_output, 1'b0});
   endtask
   task automatic t_reset;
      xf(scf_pkg::ADDR_SECOND_CURRENT_DRIVER_CTL, 11'h123);
      chk("msg1 reset", rx, 16'h0000);
      chk("ctl", 16'(second_current_driver_ctl), 16'h0123);
      xf(NOP, 11'h000);
      chk("msg2 reset", rx, 16'h4000);
      trimmed <= 1'b1;
      xf(NOP, 11'h000);
      chk("msg2 trim", rx, TRIM);
      $display("t_reset done");
   endtask
   task automatic t_second_current_driver;
      xf(scf_pkg::ADDR_SECOND_CURRENT_DRIVER_FA, {1'b1, 3'b000, 3'd5, 4'hA});
      chk("retry", 16'(second_current_driver_retry), 16'h0001);
      chk("amp", 16'(second_current_driver_amp), 16'h0005);
      chk("freq", 16'(second_current_driver_freq), 16'h000A);
      xf(scf_pkg::ADDR_INVAL_A, 11'h7FF);
      xf(scf_pkg::ADDR_INVAL_B, 11'h000);
      chk("amp kept", 16'(second_current_driver_amp), 16'h0005);
      chk("freq kept", 16'(second_current_driver_freq), 16'h000A);
      chk("ctl kept", 16'(second_current_driver_ctl), 16'h0123);
      $display("t_second_current_driver done");
   endtask
   task automatic t_thermal_limit;
      msg_select <= 1'b0;
      out_fault <= 8'h3C;
      tl(8'h81, 4'b1011);
      xf(NOP, 11'h000);
      chk("msg1 fault", rx, 16'h803C);
      tl(8'h00, 4'b0100);
      xf(NOP, 11'h000);
      chk("msg1 clean", rx, 16'h003C);
      msg_select <= 1'b1;
      out_fault <= 8'h00;
      $display("t_thermal_limit done");
   endtask
   task automatic t_open;
      out_cmd_on <= 8'h02;
      pulldown_dis <= 8'h04;
      xf(NOP, 11'h000);
      open_cmp <= 8'h07;
      xf(NOP, 11'h000);
      chk("ol filtered", rx, TRIM);
      tick(80);
      open_cmp <= 8'h00;
      xf(NOP, 11'h000);
      chk("ol latched", rx, 16'h2001);
      chk("sfr", sfr, 16'h2001);
      xf(NOP, 11'h000);
      chk("ol cleared", rx, TRIM);
      $display("t_open done");
   endtask
   task automatic t_power;
      out_cmd_on <= 8'hA5;
      pulldown_dis <= 8'h00;
      low_voltage <= 1'b1;
      tick(2);
      chk("oe low", 16'(out_enable), 16'h00A5);
      chk("unrel", 16'(status_unreliable), 16'h0001);
      chk("pd on", 16'(pulldown_en), 16'h00FF);
      sleep_mode <= 1'b1;
      over_voltage_flag <= 1'b1;
      tick(2);
      chk("pd sleep", 16'(pulldown_en), 16'h0000);
      chk("oe ov", 16'(out_enable), 16'h0000);
      sleep_mode <= 1'b0;
      pulldown_dis <= 8'h0F;
      over_voltage_flag <= 1'b0;
      tick(2);
      chk("pd cmd", 16'(pulldown_en), 16'h00F0);
      chk("oe back", 16'(out_enable), 16'h00A5);
      under_voltage <= 1'b1;
      tick(3);
      chk("oe uv", 16'(out_enable), 16'h0000);
      chk("amp uv", 16'(second_current_driver_amp), 16'h0000);
      chk("ctl uv", 16'(second_current_driver_ctl), 16'h0000);
      $display("t_power done");
   endtask
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors++;
         stop_test();
      end
   end
   initial begin
      reset_n = 1'b0;
      {out_cmd_on, pulldown_dis, open_cmp, out_fault, thermal_limit_oss} = '0;
      {sleep_mode, thermal_limit_first_current_driver, cal_freq_high, cal_freq_low} = '0;
      {over_voltage_flag, under_voltage, low_voltage, trimmed} = '0;
      msg_select = 1'b1;
      tick(8);
      reset_n <= 1'b1;
      tick(8);
      t_reset();
      t_second_current_driver();
      t_thermal_limit();
      t_open();
      t_power();
      stop_test();
   end
endmodule
`default_nettype wire
